// [hw/ess_defines.svh]
// Constants of the engine starter sequencer: timing, thresholds, limits.
// Assumes a single system clock; included by the design files and the bench.
`ifndef ESS_DEFINES_SVH
`define ESS_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define ESS_CLK_PERIOD_NS 8
`define ESS_TICK_PERIOD_NS 1000000
`define ESS_BUS_DELAY_MS 1000
`define ESS_MISMATCH_MS 1000
`define ESS_INJ_HOLD_MS 2000
`define ESS_TMR_W 16

// ****************************************
// Speeds
// ****************************************
`define ESS_RESUME_RPM 16'h0032
`define ESS_RAMP_STEP 16'h0010
`define ESS_IDLE_RESET 16'h0000

`endif

// [hw/ess_pkg.sv]
// Types shared by the engine starter sequencer.
// Needs nothing but itself.
package ess_pkg;
  typedef enum logic [1:0] {
    ESS_IDLE = 2'b00,
    ESS_WAIT = 2'b01,
    ESS_CRANK = 2'b10,
    ESS_LOCK = 2'b11
  } ess_state_e;

  typedef enum logic [1:0] {
    ESS_SRC_NONE = 2'b00,
    ESS_SRC_WIRED = 2'b01,
    ESS_SRC_BUS = 2'b10,
    ESS_SRC_BTN = 2'b11
  } ess_src_e;
endpackage

// [hw/ess_timer.sv]
// Tick-driven delay counter of the engine starter sequencer.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "ess_defines.svh"
module ess_timer #(
  parameter int W = `ESS_TMR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  // Result
  output logic done
);
  logic [W-1:0] count;

  // Holds at limit so done stays up until run drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (tick && count < limit) begin
      count <= count + 1'b1;
    end
  end

  assign done = run && (count >= limit);
endmodule // ess_timer

// [hw/ess_starter.sv]
// Starter sequencer: main/aux path drive, reset bridge, bus and button starts.
// Assumes pins are asynchronous; bus and system signals share clk.
// Notes on behaviour
// - Wired start without short circuit sets a start record kept over warm restart.
// - Warm restart with start record keeps aux path released until restart ends.
// - At warm restart end a still valid start moves drive onto the main path.
// - Backup phase completion clears start record and warm restart indication.
// - Bridge keeps immobilizer disabled only if it was disabled before the drop.
// - Normal cranking drives both series main path switches together.
// - Outside the bridge, aux path released only after main path active and no output level seen.
// - Aux path has its own release output, apart from the main switches.
// - Driver faults come from output level sensing and main path short detect.
// - Bus-only start demand waits one second before engaging, if authorized.
// - Bus start stops on protection or wired line or button toggled on-off.
// - Start aborts when the configured maximum starting time is exceeded.
// - Button start needs ignition on and starter not locked.
// - Button start refused in bus backup or when configured without bus.
// - Button press requests start on bus; crank only after controller confirms.
// - Button release stops starter; bus request ignored until withdrawn.
// - Stop button shuts engine off and reports stop to the controller.
// - Stop during button cranking keeps starter but inhibits injection.
// - Injection returns on both released and stopped, or start held two seconds.
// - Later presses ramp idle setpoint to max limit; release restores idle.
// - Rev-up stays armed until engine speed reaches zero.
// - External stop must be held; release above 50 rpm resumes running.
// - Wired and bus start disagreeing over one second flags fault, delays start.
`timescale 1ns/1ps
`include "ess_defines.svh"
module ess_starter
  import ess_pkg::*;
#(
  parameter int TICK_CYCLES = `ESS_TICK_PERIOD_NS / `ESS_CLK_PERIOD_NS,
  parameter int TICKS_PER_MS = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pins
  input wire logic wired_start_req,
  input wire logic svc_start_btn,
  input wire logic svc_stop_btn,
  input wire logic ignition_on,
  input wire logic starter_output_level,
  input wire logic main_path_short_detect,
  // Vehicle controller over the bus
  input wire logic bus_start_demand,
  input wire logic bus_start_confirm,
  input wire logic bus_start_authorized,
  input wire logic bus_backup_mode,
  input wire logic ext_stop_btn,
  output logic bus_start_request,
  output logic engine_stop_report,
  // System state and configuration
  input wire logic cfg_no_bus,
  input wire logic starter_locked,
  input wire logic protection_trip,
  input wire logic [`ESS_TMR_W-1:0] cfg_max_start_ticks,
  input wire logic warm_restart_active,
  input wire logic backup_phase_done,
  input wire logic immo_disabled_before,
  input wire logic [15:0] engine_speed,
  input wire logic [15:0] base_idle,
  input wire logic [15:0] max_speed_limit,
  // Starter driver
  output logic main_path_switch_a,
  output logic main_path_switch_b,
  output logic aux_path_release,
  // Status
  output logic start_record,
  output logic warm_restart_flag,
  output logic immo_keep_disabled,
  output logic driver_fault,
  output logic start_line_fault,
  output logic injection_inhibit,
  output logic [15:0] idle_setpoint
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= {wired_start_req, svc_start_btn, svc_stop_btn, ignition_on,
                   starter_output_level, main_path_short_detect};
      pin_sync <= pin_meta;
    end
  end
  logic wired_s, btn_s, stop_s, ign_s, level_s, short_s;
  assign {wired_s, btn_s, stop_s, ign_s, level_s, short_s} = pin_sync;

  // ****************************************
  // Tick and timers
  // ****************************************
  logic [TW-1:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
    end
  end
  assign tick = (tick_cnt == TICK_LAST);

  // Timer 0: start delay, 1: max start, 2: injection hold
  logic [2:0] tmr_run;
  logic [2:0] tmr_done;
  logic [`ESS_TMR_W-1:0] tmr_lim [3];
  assign tmr_lim[0] = `ESS_TMR_W'(`ESS_BUS_DELAY_MS * TICKS_PER_MS);
  assign tmr_lim[1] = cfg_max_start_ticks;
  assign tmr_lim[2] = `ESS_TMR_W'(`ESS_INJ_HOLD_MS * TICKS_PER_MS);
  for (genvar i = 0; i < 3; i++) begin : g_tmr
    ess_timer #(.W(`ESS_TMR_W)) u_tmr (
      .clk(clk),
      .arst_n(arst_n),
      .tick(tick),
      .run(tmr_run[i]),
      .limit(tmr_lim[i]),
      .done(tmr_done[i])
    );
  end

  // ****************************************
  // Start sequencing
  // ****************************************
  ess_state_e state;
  ess_src_e src;
  logic bus_ignore, toggle_seen, bridge_active, warm_prev, main_on_d;
  logic btn_started, crank_only, revup_armed, short_seen;
  logic btn_ok, bus_go, mismatch, crank_stop, next_bridge_end;

  assign btn_ok = ign_s && !starter_locked && !bus_backup_mode && !cfg_no_bus;
  assign bus_go = bus_start_demand && !bus_ignore && !wired_s && !btn_s;
  assign mismatch = wired_s != bus_start_demand;
  assign next_bridge_end = bridge_active && !warm_restart_active;

  always_comb begin
    crank_stop = protection_trip || tmr_done[1];
    unique case (src)
      ESS_SRC_WIRED: crank_stop = crank_stop || !wired_s;
      ESS_SRC_BTN: crank_stop = crank_stop || !btn_s;
      ESS_SRC_BUS: crank_stop = crank_stop || !bus_start_demand ||
                                (toggle_seen && !wired_s && !btn_s);
      ESS_SRC_NONE: crank_stop = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ESS_IDLE;
      src <= ESS_SRC_NONE;
    end else begin
      unique case (state)
        ESS_IDLE: begin
          if (next_bridge_end && wired_s) begin
            state <= ESS_CRANK;
            src <= ESS_SRC_WIRED;
          end else if (wired_s && !starter_locked && !bridge_active) begin
            src <= ESS_SRC_WIRED;
            // Disagreement holds the start back for the check period
            state <= (mismatch && !cfg_no_bus && !bus_backup_mode) ? ESS_WAIT : ESS_CRANK;
          end else if (btn_s && btn_ok && bus_start_confirm && !bus_ignore) begin
            state <= ESS_CRANK;
            src <= ESS_SRC_BTN;
          end else if (bus_go && !starter_locked) begin
            state <= ESS_WAIT;
            src <= ESS_SRC_BUS;
          end
        end
        ESS_WAIT: begin
          if (starter_locked || (src == ESS_SRC_BUS ? !bus_start_demand : !wired_s)) begin
            state <= ESS_LOCK;
          end else if (tmr_done[0] && (src != ESS_SRC_BUS || bus_start_authorized)) begin
            state <= ESS_CRANK;
          end
        end
        ESS_CRANK: begin
          if (crank_stop) begin
            state <= ESS_LOCK;
          end
        end
        ESS_LOCK: begin
          // All sources must be withdrawn before any source may start again
          if (!wired_s && !btn_s && !bus_start_demand) begin
            state <= ESS_IDLE;
            src <= ESS_SRC_NONE;
          end
        end
      endcase
    end
  end

  assign tmr_run[0] = (state == ESS_WAIT);
  assign tmr_run[1] = (state == ESS_CRANK);
  assign tmr_run[2] = crank_only && btn_s && !stop_s;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      toggle_seen <= 1'b0;
    end else if (state != ESS_CRANK || src != ESS_SRC_BUS) begin
      toggle_seen <= 1'b0;
    end else if (wired_s || btn_s) begin
      toggle_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_ignore <= 1'b0;
    end else if (state == ESS_CRANK && src == ESS_SRC_BTN && !btn_s) begin
      bus_ignore <= 1'b1;
    end else if (!bus_start_demand) begin
      bus_ignore <= 1'b0;
    end
  end

  assign bus_start_request = btn_s && btn_ok && !bus_ignore &&
                             (state == ESS_IDLE || state == ESS_CRANK);

  // ****************************************
  // Reset bridge
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      short_seen <= 1'b0;
    end else if (state != ESS_CRANK) begin
      short_seen <= 1'b0;
    end else if (short_s) begin
      short_seen <= 1'b1;
    end
  end

  // Reset or backup phase completion clears the record; a warm restart leaves it standing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_record <= 1'b0;
    end else if (state == ESS_CRANK && src == ESS_SRC_WIRED && !short_seen && !short_s) begin
      start_record <= 1'b1;
    end else if (backup_phase_done) begin
      start_record <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_prev <= 1'b0;
      bridge_active <= 1'b0;
    end else begin
      warm_prev <= warm_restart_active;
      if (warm_restart_active && !warm_prev && start_record) begin
        bridge_active <= 1'b1;
      end else if (!warm_restart_active) begin
        bridge_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_restart_flag <= 1'b0;
      immo_keep_disabled <= 1'b0;
    end else if (warm_restart_active && !warm_prev) begin
      warm_restart_flag <= 1'b1;
      immo_keep_disabled <= start_record && immo_disabled_before;
    end else if (backup_phase_done) begin
      warm_restart_flag <= 1'b0;
      immo_keep_disabled <= 1'b0;
    end
  end

  // ****************************************
  // Starter driver
  // ****************************************
  logic drive;
  assign drive = (state == ESS_CRANK);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      main_path_switch_a <= 1'b0;
      main_path_switch_b <= 1'b0;
      main_on_d <= 1'b0;
      aux_path_release <= 1'b0;
    end else begin
      main_path_switch_a <= drive;
      main_path_switch_b <= drive;
      main_on_d <= drive && main_path_switch_a;
      // Aux path lacks short protection, so outside the bridge it only backs up a dead main path
      aux_path_release <= bridge_active ||
                          (drive && main_on_d && !level_s && !short_s);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      driver_fault <= 1'b0;
    end else begin
      driver_fault <= (short_s && main_path_switch_a) ||
                      (level_s && !main_path_switch_a && !aux_path_release);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_line_fault <= 1'b0;
    end else if (state == ESS_WAIT && src == ESS_SRC_WIRED && tmr_done[0] && mismatch) begin
      start_line_fault <= 1'b1;
    end else if (!mismatch) begin
      start_line_fault <= 1'b0;
    end
  end

  // ****************************************
  // Service buttons, injection, rev-up
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crank_only <= 1'b0;
    end else if (stop_s && drive && src == ESS_SRC_BTN) begin
      crank_only <= 1'b1;
    end else if ((!btn_s && !stop_s && engine_speed == 16'h0000) || tmr_done[2]) begin
      crank_only <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      engine_stop_report <= 1'b0;
      injection_inhibit <= 1'b0;
    end else begin
      engine_stop_report <= stop_s;
      // External stop only holds while pressed; early release resumes
      injection_inhibit <= crank_only || stop_s || ext_stop_btn;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      btn_started <= 1'b0;
      revup_armed <= 1'b0;
    end else begin
      if (drive && src == ESS_SRC_BTN) begin
        btn_started <= 1'b1;
      end else if (engine_speed == 16'h0000) begin
        btn_started <= 1'b0;
      end
      if (engine_speed == 16'h0000) begin
        revup_armed <= 1'b0;
      end else if (btn_started && !btn_s && state != ESS_CRANK) begin
        revup_armed <= 1'b1;
      end
    end
  end

  logic revup_on;
  assign revup_on = revup_armed && btn_s && state == ESS_IDLE;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_setpoint <= `ESS_IDLE_RESET;
    end else if (!revup_on) begin
      idle_setpoint <= base_idle;
    end else if (idle_setpoint == base_idle && engine_speed > base_idle) begin
      idle_setpoint <= engine_speed;
    end else if (tick) begin
      idle_setpoint <= (max_speed_limit - idle_setpoint > `ESS_RAMP_STEP) ?
                       idle_setpoint + `ESS_RAMP_STEP : max_speed_limit;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_MAIN_PAIR: assert property (main_path_switch_a == main_path_switch_b)
    else $error("main path switches differ");
  AST_AUX_AFTER_MAIN: assert property (
    aux_path_release && !$past(bridge_active) |-> $past(main_path_switch_a, 2))
    else $error("aux path released before main path");
  AST_BRIDGE_AUX: assert property (bridge_active |=> aux_path_release)
    else $error("bridge without aux release");
  AST_BACKUP_CLEAR: assert property (
    backup_phase_done && state != ESS_CRANK && !(warm_restart_active && !warm_prev)
    |=> !start_record && !warm_restart_flag)
    else $error("backup end did not clear flags");
  AST_RECORD_CAUSE: assert property ($rose(start_record) |->
    $past(state == ESS_CRANK && src == ESS_SRC_WIRED && !short_s))
    else $error("start record without wired start");
  AST_MAX_TIME: assert property (drive && tmr_done[1] |=> state == ESS_LOCK)
    else $error("start not aborted at max time");
  AST_BTN_GATE: assert property (bus_start_request |->
    ign_s && !starter_locked && !bus_backup_mode && !cfg_no_bus)
    else $error("button request while refused");
  AST_BTN_RELEASE: assert property (
    drive && src == ESS_SRC_BTN && !btn_s |=> !drive ##1 !main_path_switch_a)
    else $error("starter held after button release");
  AST_CRANK_ONLY: assert property (crank_only |=> injection_inhibit)
    else $error("injection during crank only");

  COV_BUS_START: cover property (state == ESS_WAIT && src == ESS_SRC_BUS ##1 drive);
  COV_BRIDGE: cover property (bridge_active ##[1:50] drive);
  COV_CRANK_ONLY: cover property ($rose(crank_only));
endmodule // ess_starter

// [sim/ess_vehicle_ctl.sv]
// Behavioural vehicle controller on the far side of the starter sequencer.
// Assumes the bench commands it at the falling edge; answers follow clk.
`timescale 1ns/1ps
module ess_vehicle_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Commands from the bench
  input wire logic cmd_demand,
  input wire logic cmd_neutral,
  input wire logic cmd_backup,
  input wire logic cmd_ext_stop,
  input wire logic [7:0] confirm_lag,
  // Request from the device
  input wire logic bus_start_request,
  // Bus signals to the device
  output logic bus_start_demand,
  output logic bus_start_confirm,
  output logic bus_start_authorized,
  output logic bus_backup_mode,
  output logic ext_stop_btn
);
  logic [7:0] lag_cnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {bus_start_demand, bus_start_authorized, bus_backup_mode, ext_stop_btn} <= 4'h0;
    end else begin
      bus_start_demand <= cmd_demand;
      bus_start_authorized <= cmd_neutral;
      bus_backup_mode <= cmd_backup;
      ext_stop_btn <= cmd_ext_stop;
    end
  end

  // Confirm only a request seen in neutral, after a lag; withdraw at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lag_cnt <= 8'h00;
      bus_start_confirm <= 1'b0;
    end else if (bus_start_request && cmd_neutral) begin
      if (lag_cnt >= confirm_lag) begin
        bus_start_confirm <= 1'b1;
      end else begin
        lag_cnt <= lag_cnt + 8'h01;
      end
    end else begin
      lag_cnt <= 8'h00;
      bus_start_confirm <= 1'b0;
    end
  end
endmodule  // ess_vehicle_ctl

// [sim/ess_starter_bench.sv]
// Self-checking bench of the engine starter sequencer.
// Assumes a 125 MHz clock, tick of 4 cycles and the vehicle controller model.
`timescale 1ns/1ps
`include "ess_defines.svh"
module ess_starter_bench
  import ess_pkg::*;
;
  // ****
  // Signals
  // ****
  localparam int TICK = 4;
  localparam logic [10:0] SW = 11'h600, AUX = 11'h100, REC = 11'h080, WRM = 11'h040;
  localparam logic [10:0] IMM = 11'h020, DRV = 11'h010, LNF = 11'h008, INJ = 11'h004;
  localparam logic [10:0] REQ = 11'h002, STP = 11'h001;
  typedef struct {logic idl; logic [15:0] m; logic [15:0] v;} ess_note_s;
  ess_note_s notes[$];
  ess_note_s cur;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 73178;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wired_start_req, svc_start_btn, svc_stop_btn, ignition_on, starter_output_level;
  logic main_path_short_detect, cfg_no_bus, starter_locked, protection_trip;
  logic warm_restart_active, backup_phase_done, immo_disabled_before;
  logic cmd_demand, cmd_neutral, cmd_backup, cmd_ext_stop;
  logic [7:0] confirm_lag;
  logic [`ESS_TMR_W-1:0] cfg_max_start_ticks;
  logic [15:0] engine_speed, base_idle, max_speed_limit, idle_setpoint;
  logic bus_start_demand, bus_start_confirm, bus_start_authorized, bus_backup_mode;
  logic ext_stop_btn, bus_start_request, engine_stop_report, main_path_switch_a;
  logic main_path_switch_b, aux_path_release, start_record, warm_restart_flag;
  logic immo_keep_disabled, driver_fault, start_line_fault, injection_inhibit;
  wire logic [10:0] obs = {main_path_switch_a, main_path_switch_b, aux_path_release,
    start_record, warm_restart_flag, immo_keep_disabled, driver_fault, start_line_fault,
    injection_inhibit, bus_start_request, engine_stop_report};

  always #4 clk = ~clk;

  // Short tick keeps the one and two second waits affordable
  ess_starter #(.TICK_CYCLES(TICK), .TICKS_PER_MS(1)) DUT (.clk, .arst_n, .wired_start_req,
    .svc_start_btn, .svc_stop_btn, .ignition_on, .starter_output_level,
    .main_path_short_detect, .bus_start_demand, .bus_start_confirm, .bus_start_authorized,
    .bus_backup_mode, .ext_stop_btn, .bus_start_request, .engine_stop_report, .cfg_no_bus,
    .starter_locked, .protection_trip, .cfg_max_start_ticks, .warm_restart_active,
    .backup_phase_done, .immo_disabled_before, .engine_speed, .base_idle, .max_speed_limit,
    .main_path_switch_a, .main_path_switch_b, .aux_path_release, .start_record,
    .warm_restart_flag, .immo_keep_disabled, .driver_fault, .start_line_fault,
    .injection_inhibit, .idle_setpoint);

  ess_vehicle_ctl u_vc (.clk, .arst_n, .cmd_demand, .cmd_neutral, .cmd_backup,
    .cmd_ext_stop, .confirm_lag, .bus_start_request, .bus_start_demand, .bus_start_confirm,
    .bus_start_authorized, .bus_backup_mode, .ext_stop_btn);

  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [10:0] m, input logic [10:0] v);
    notes.push_back('{1'b0, {5'h00, m}, {5'h00, v}});
  endtask
  task automatic note_idle(input logic [15:0] v);
    notes.push_back('{1'b1, 16'hFFFF, v});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ticks(input int n);
    cyc(n * TICK);
  endtask
  // Sources must all drop before the sequencer leaves its lock
  task automatic quiet;
    {wired_start_req, svc_start_btn, svc_stop_btn, cmd_demand, protection_trip} = 5'h00;
    cyc(20);
  endtask
  // Pin path lags the bus by one flop, so the demand follows a cycle later
  task automatic start_both;
    wired_start_req = 1'b1;
    cyc(1);
    cmd_demand = 1'b1;
  endtask
  task automatic finish_test;
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****
  // Scoreboard
  // ****
  always @(posedge clk) begin
    #2;
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.idl)
        check(idle_setpoint, cur.v);
      else
        check({5'h00, obs} & cur.m, cur.v);
    end
  end

  initial begin
    #320000;
    num_errors++;
    finish_test();
  end

  // ****
  // Stimulus
  // ****
  initial begin
    {wired_start_req, svc_start_btn, svc_stop_btn, ignition_on, starter_output_level} = 5'h00;
    {main_path_short_detect, cfg_no_bus, starter_locked, protection_trip} = 4'h0;
    {warm_restart_active, backup_phase_done, immo_disabled_before} = 3'h0;
    {cmd_demand, cmd_neutral, cmd_backup, cmd_ext_stop, confirm_lag} = 12'h000;
    {engine_speed, base_idle, max_speed_limit} = 48'h0;
    cfg_max_start_ticks = 16'h0FA0;
    cyc(4);
    arst_n = 1'b1;
    note(11'h7FF, 11'h000);
    note_idle(16'h0000);
    starter_output_level = 1'b1;
    cyc(10);
    note(DRV, DRV);
    starter_output_level = 1'b0;
    main_path_short_detect = 1'b1;
    cyc(10);
    note(DRV, 11'h000);
    start_both();
    cyc(12);
    note(REC, 11'h000);
    quiet();
    main_path_short_detect = 1'b0;
    immo_disabled_before = 1'b1;
    start_both();
    cyc(12);
    note(SW | AUX | REC, SW | AUX | REC);
    quiet();
    // Record outlives the crank; bridge holds the aux path while idle
    warm_restart_active = 1'b1;
    start_both();
    cyc(6);
    note(SW | AUX | WRM | IMM, AUX | WRM | IMM);
    warm_restart_active = 1'b0;
    cyc(6);
    note(SW, SW);
    quiet();
    backup_phase_done = 1'b1;
    cyc(1);
    backup_phase_done = 1'b0;
    cyc(4);
    note(REC | WRM | IMM, 11'h000);
    note(SW | AUX, 11'h000);
    cfg_max_start_ticks = 16'h0014;
    starter_output_level = 1'b1;
    start_both();
    cyc(12);
    note(SW | AUX, SW);
    ticks(25);
    note(SW, 11'h000);
    quiet();
    starter_output_level = 1'b0;
    cfg_max_start_ticks = 16'h0FA0;
    wired_start_req = 1'b1;
    ticks(900);
    note(SW | LNF, 11'h000);
    ticks(200);
    note(LNF, LNF);
    quiet();
    for (int k = 0; k < 3; k++) begin
      {cmd_neutral, cmd_demand} = {k != 0, 1'b1};
      ticks(900);
      note(SW, 11'h000);
      ticks(200);
      note(SW, (k != 0) ? SW : 11'h000);
      if (k == 1) begin
        wired_start_req = 1'b1;
        cyc(10);
        wired_start_req = 1'b0;
      end else begin
        protection_trip = 1'b1;
      end
      cyc(10);
      note(SW, 11'h000);
      quiet();
    end
    for (int k = 0; k < 4; k++) begin
      {ignition_on, starter_locked, cmd_backup, cfg_no_bus} = (k == 0) ? 4'h0 : 4'h8 | 4'(4'h8 >> k);
      svc_start_btn = 1'b1;
      cyc(40);
      note(SW, 11'h000);
      quiet();
    end
    {ignition_on, starter_locked, cmd_backup, cfg_no_bus} = 4'h8;
    confirm_lag = {4'h0, 4'($random(seed))} + 8'h01;
    svc_start_btn = 1'b1;
    cyc(40);
    note(SW | REQ, SW | REQ);
    svc_stop_btn = 1'b1;
    cyc(10);
    note(SW | INJ | STP, SW | INJ | STP);
    svc_stop_btn = 1'b0;
    ticks(1900);
    note(INJ, INJ);
    ticks(200);
    note(INJ, 11'h000);
    // Engine already runs above idle when the button lets go, arming rev-up
    engine_speed = 16'h0300 + {6'h00, 10'($random(seed))};
    base_idle = 16'h0258;
    max_speed_limit = engine_speed + 16'h00A0;
    svc_start_btn = 1'b0;
    cyc(10);
    note(SW, 11'h000);
    starter_locked = 1'b1;
    svc_start_btn = 1'b1;
    ticks(20);
    note_idle(max_speed_limit);
    svc_start_btn = 1'b0;
    cyc(5);
    note_idle(base_idle);
    engine_speed = 16'h0000;
    cyc(10);
    engine_speed = max_speed_limit - 16'h00A0;
    svc_start_btn = 1'b1;
    ticks(20);
    note_idle(base_idle);
    quiet();
    engine_speed = 16'h0064;
    cmd_ext_stop = 1'b1;
    cyc(10);
    note(INJ, INJ);
    cmd_ext_stop = 1'b0;
    cyc(10);
    note(INJ, 11'h000);
    cyc(5);
    finish_test();
  end
endmodule  // ess_starter_bench
